// ===== common/fps_map.svh
// register offsets, field positions and reset values of the flat panel power sequencer
// Functional notes
// - power-up: supply on, wait signal delay upper field plus one pulses, then timing outputs on
// - marker, line pulse, shift clock, upper and lower data switch as one group
// - power-down: timing outputs off, wait signal delay lower field, then supply off
// - power-up: timing outputs on, wait bias delay upper field, then bias on
// - power-down: bias off, wait bias delay lower field, then timing outputs off
// - power-up: bias on, wait display delay upper field, then display-on high
// - power-down: display-on low, wait display delay lower field, then bias off
// - delays chain, so an earlier field shifts every later transition
// - signal delay resets to 31h, bias delay to 23h, both read/write
// - display delay resets to 12h
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define FPS_IDX_SIGNAL_DELAY  8'h14
`define FPS_IDX_BIAS_DELAY    8'h15
`define FPS_IDX_DISPLAY_DELAY 8'h16

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define FPS_RST_SIGNAL_DELAY  8'h31
`define FPS_RST_BIAS_DELAY    8'h23
`define FPS_RST_DISPLAY_DELAY 8'h12
`define FPS_UP_FIELD          7:4
`define FPS_DOWN_FIELD        3:0
`define FPS_DATA_WIDTH        12

`endif

// ===== common/fps_pkg.sv
// types shared by the flat panel power sequencer modules
package fps_pkg;

    // sequence steps; every wait state runs one delay counter
    typedef enum logic [2:0] {
        FPS_ST_OFF,
        FPS_ST_UP_SIG,
        FPS_ST_UP_BIAS,
        FPS_ST_UP_DISP,
        FPS_ST_ON,
        FPS_ST_DN_DISP,
        FPS_ST_DN_BIAS,
        FPS_ST_DN_SIG
    } fps_state_e;

    // register file state
    typedef struct packed {
        logic [7:0] signal_delay;
        logic [7:0] bias_delay;
        logic [7:0] display_delay;
        logic [7:0] rdata;
    } fps_regs_s;

    // sequencer state, panel pins included
    typedef struct packed {
        fps_state_e  state;
        logic        supply;
        logic        sig_en;
        logic        bias;
        logic        disp;
        logic        marker;
        logic        latch;
        logic        shclk;
        logic [11:0] upper;
        logic [11:0] lower;
    } fps_seq_s;

endpackage : fps_pkg

// ===== src/fps_step_counter.sv
// frame sync pulse counter for one sequence step
`timescale 1ns/1ps
module fps_step_counter #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,    // pixel clock
    input  wire logic             rstn_i,   // async reset, active low
    input  wire logic             ce_i,     // clock enable
    input  wire logic             load_i,   // step begins
    input  wire logic [WIDTH-1:0] load_val_i, // delay field
    input  wire logic             tick_i,   // frame sync pulse
    output logic                  done_o    // step ends, one-cycle pulse
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             busy;
    } fps_cnt_s;

    fps_cnt_s q;
    fps_cnt_s next_q;

    // a zero count ends the step on the next pulse
    assign done_o = ce_i & tick_i & q.busy & (q.cnt == '0);

    // load wins over done so back-to-back steps chain without a gap
    always_comb begin
        next_q = q;
        if (ce_i) begin
            if (load_i) begin
                next_q.cnt  = load_val_i;
                next_q.busy = 1'b1;
            end else if (tick_i && q.busy) begin
                if (q.cnt == '0) begin
                    next_q.busy = 1'b0;
                end else begin
                    next_q.cnt = q.cnt - 1'b1;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule : fps_step_counter

// ===== src/fps_regs.sv
// delay register file reached by index, read data registered
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_regs
    import fps_pkg::*;
(
    input  wire logic       clk_i,          // pixel clock
    input  wire logic       rstn_i,         // async reset, active low
    input  wire logic       ce_i,           // clock enable
    input  wire logic [7:0] reg_index_i,    // register index
    input  wire logic       reg_write_i,    // write strobe
    input  wire logic [7:0] reg_wdata_i,    // write data
    output logic      [7:0] reg_rdata_o,    // read data of last index
    output logic      [7:0] signal_delay_o, // signal delay register
    output logic      [7:0] bias_delay_o,   // bias enable delay register
    output logic      [7:0] display_delay_o // display on/off delay register
);
    localparam fps_regs_s REGS_RESET = '{
        signal_delay:  `FPS_RST_SIGNAL_DELAY,
        bias_delay:    `FPS_RST_BIAS_DELAY,
        display_delay: `FPS_RST_DISPLAY_DELAY,
        rdata:         8'h00
    };

    fps_regs_s q;
    fps_regs_s next_q;

    // index decode, shared by write and read: 0 means unmapped
    function automatic logic [1:0] reg_sel(input logic [7:0] idx);
        case (idx)
            `FPS_IDX_SIGNAL_DELAY:  reg_sel = 2'h1;
            `FPS_IDX_BIAS_DELAY:    reg_sel = 2'h2;
            `FPS_IDX_DISPLAY_DELAY: reg_sel = 2'h3;
            default:                reg_sel = 2'h0;
        endcase
    endfunction : reg_sel

    // writes land at once; reads of reserved indices give zero
    always_comb begin
        next_q = q;
        if (ce_i) begin
            if (reg_write_i) begin
                case (reg_sel(reg_index_i))
                    2'h1:    next_q.signal_delay  = reg_wdata_i;
                    2'h2:    next_q.bias_delay    = reg_wdata_i;
                    2'h3:    next_q.display_delay = reg_wdata_i;
                    default: next_q.rdata         = q.rdata;
                endcase
            end
            case (reg_sel(reg_index_i))
                2'h1:    next_q.rdata = next_q.signal_delay;
                2'h2:    next_q.rdata = next_q.bias_delay;
                2'h3:    next_q.rdata = next_q.display_delay;
                default: next_q.rdata = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= REGS_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign reg_rdata_o     = q.rdata;
    assign signal_delay_o  = q.signal_delay;
    assign bias_delay_o    = q.bias_delay;
    assign display_delay_o = q.display_delay;

endmodule : fps_regs

// ===== src/fps_sequencer.sv
// flat panel power-up/power-down sequencer, top level
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_sequencer
    import fps_pkg::*;
#(
    parameter int DATA_WIDTH = `FPS_DATA_WIDTH,
    parameter int CNT_WIDTH  = 4
) (
    input  wire logic                  clk_i,                    // pixel clock, 100 MHz
    input  wire logic                  rstn_i,                   // async reset, active low
    input  wire logic                  ce_i,                     // clock enable
    input  wire logic                  panel_on_req_i,           // 1 = panel on, 0 = off
    input  wire logic                  frame_sync_pulse_i,       // one-cycle frame pulse
    input  wire logic [7:0]            reg_index_i,              // register index
    input  wire logic                  reg_write_i,              // register write strobe
    input  wire logic [7:0]            reg_wdata_i,              // register write data
    output logic      [7:0]            reg_rdata_o,              // register read data
    input  wire logic                  marker_src_i,             // marker from timing gen
    input  wire logic                  latch_src_i,              // line pulse from timing gen
    input  wire logic                  shclk_src_i,              // shift clock from timing gen
    input  wire logic [DATA_WIDTH-1:0] upper_src_i,              // upper data from pipeline
    input  wire logic [DATA_WIDTH-1:0] lower_src_i,              // lower data from pipeline
    output logic                       panel_logic_supply_enable_o, // logic supply enable
    output logic                       panel_bias_enable_o,      // bias supply enable
    output logic                       display_on_control_o,     // high = display on
    output logic                       first_line_marker_o,      // gated frame marker
    output logic                       line_latch_pulse_o,       // gated line pulse
    output logic                       pixel_shift_clock_out_o,  // gated shift clock
    output logic      [DATA_WIDTH-1:0] upper_half_data_o,        // gated upper data
    output logic      [DATA_WIDTH-1:0] lower_half_data_o,        // gated lower data
    output logic                       panel_on_o,               // sequence finished on
    output logic                       sequence_busy_o           // a step is running
);
    // ****************************************************************
    // registers and step counter
    // ****************************************************************
    logic [7:0]           signal_delay;
    logic [7:0]           bias_delay;
    logic [7:0]           display_delay;
    logic                 step_load;
    logic [CNT_WIDTH-1:0] step_val;
    logic                 step_done;

    // delay registers, read back on the same index port
    fps_regs u_regs (
        .clk_i           (clk_i),
        .rstn_i          (rstn_i),
        .ce_i            (ce_i),
        .reg_index_i     (reg_index_i),
        .reg_write_i     (reg_write_i),
        .reg_wdata_i     (reg_wdata_i),
        .reg_rdata_o     (reg_rdata_o),
        .signal_delay_o  (signal_delay),
        .bias_delay_o    (bias_delay),
        .display_delay_o (display_delay)
    );

    // one counter serves all steps since only one step runs at a time
    fps_step_counter #(
        .WIDTH (CNT_WIDTH)
    ) u_cnt (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .ce_i       (ce_i),
        .load_i     (step_load),
        .load_val_i (step_val),
        .tick_i     (frame_sync_pulse_i),
        .done_o     (step_done)
    );

    // ****************************************************************
    // delay field for the wait state being entered
    // ****************************************************************
    // fields are sampled at step start, so a write mid-step affects later steps only
    function automatic logic [3:0] delay_for(input fps_state_e st,
                                             input logic [7:0] sig,
                                             input logic [7:0] bias,
                                             input logic [7:0] disp);
        case (st)
            FPS_ST_UP_SIG:  delay_for = sig[`FPS_UP_FIELD];
            FPS_ST_UP_BIAS: delay_for = bias[`FPS_UP_FIELD];
            FPS_ST_UP_DISP: delay_for = disp[`FPS_UP_FIELD];
            FPS_ST_DN_DISP: delay_for = disp[`FPS_DOWN_FIELD];
            FPS_ST_DN_BIAS: delay_for = bias[`FPS_DOWN_FIELD];
            FPS_ST_DN_SIG:  delay_for = sig[`FPS_DOWN_FIELD];
            default:        delay_for = 4'h0;
        endcase
    endfunction : delay_for

    // ****************************************************************
    // sequence state machine
    // ****************************************************************
    localparam fps_seq_s SEQ_RESET = '{state: FPS_ST_OFF, default: '0};

    fps_seq_s q;
    fps_seq_s next_q;

    // each step ends on the counter; the request is looked at only when idle,
    // so a sequence once begun always runs to its end
    always_comb begin
        next_q    = q;
        step_load = 1'b0;
        if (ce_i) begin
            case (q.state)
                FPS_ST_OFF: begin
                    if (panel_on_req_i) begin
                        next_q.supply = 1'b1;
                        next_q.state  = FPS_ST_UP_SIG;
                        step_load     = 1'b1;
                    end
                end
                FPS_ST_UP_SIG: begin
                    if (step_done) begin
                        next_q.sig_en = 1'b1;
                        next_q.state  = FPS_ST_UP_BIAS;
                        step_load     = 1'b1;
                    end
                end
                FPS_ST_UP_BIAS: begin
                    if (step_done) begin
                        next_q.bias  = 1'b1;
                        next_q.state = FPS_ST_UP_DISP;
                        step_load    = 1'b1;
                    end
                end
                FPS_ST_UP_DISP: begin
                    if (step_done) begin
                        next_q.disp  = 1'b1;
                        next_q.state = FPS_ST_ON;
                    end
                end
                FPS_ST_ON: begin
                    if (!panel_on_req_i) begin
                        next_q.disp  = 1'b0;
                        next_q.state = FPS_ST_DN_DISP;
                        step_load    = 1'b1;
                    end
                end
                FPS_ST_DN_DISP: begin
                    if (step_done) begin
                        next_q.bias  = 1'b0;
                        next_q.state = FPS_ST_DN_BIAS;
                        step_load    = 1'b1;
                    end
                end
                FPS_ST_DN_BIAS: begin
                    if (step_done) begin
                        next_q.sig_en = 1'b0;
                        next_q.state  = FPS_ST_DN_SIG;
                        step_load     = 1'b1;
                    end
                end
                FPS_ST_DN_SIG: begin
                    if (step_done) begin
                        next_q.supply = 1'b0;
                        next_q.state  = FPS_ST_OFF;
                    end
                end
                default: begin
                    next_q = SEQ_RESET;
                end
            endcase
            // timing outputs follow the group enable as one bundle
            next_q.marker = next_q.sig_en & marker_src_i;
            next_q.latch  = next_q.sig_en & latch_src_i;
            next_q.shclk  = next_q.sig_en & shclk_src_i;
            next_q.upper  = {DATA_WIDTH{next_q.sig_en}} & upper_src_i;
            next_q.lower  = {DATA_WIDTH{next_q.sig_en}} & lower_src_i;
        end
    end

    // only the low field bits feed the counter; upper bits of a wide counter stay zero
    assign step_val = CNT_WIDTH'(delay_for(next_q.state, signal_delay,
                                           bias_delay, display_delay));

    // state register; panel pins come straight from it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= SEQ_RESET;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign panel_logic_supply_enable_o = q.supply;
    assign panel_bias_enable_o         = q.bias;
    assign display_on_control_o        = q.disp;
    assign first_line_marker_o         = q.marker;
    assign line_latch_pulse_o          = q.latch;
    assign pixel_shift_clock_out_o     = q.shclk;
    assign upper_half_data_o           = q.upper;
    assign lower_half_data_o           = q.lower;
    assign panel_on_o                  = (q.state == FPS_ST_ON);
    assign sequence_busy_o             = (q.state != FPS_ST_ON) && (q.state != FPS_ST_OFF);

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // timing outputs only start while the supply is already up
    a_signal_after_supply:
        assert property ($rose(q.sig_en) |-> q.supply && $past(q.supply))
        else $error("timing outputs enabled without logic supply");

    // no member of the group is live while the group is off
    a_group_gated:
        assert property (!q.sig_en |-> !q.marker && !q.latch && !q.shclk
                         && q.upper == '0 && q.lower == '0)
        else $error("timing output active while group disabled");

    // supply drops only after the group has been off for a step
    a_supply_after_signal:
        assert property ($fell(q.supply) |-> !q.sig_en && $past(q.state) == FPS_ST_DN_SIG)
        else $error("logic supply removed before timing outputs off");

    // bias rises only on a frame pulse after the group is live
    a_bias_after_signal:
        assert property ($rose(q.bias) |-> q.sig_en && $past(frame_sync_pulse_i))
        else $error("bias enabled early");

    // group goes off only once bias is gone
    a_signal_after_bias:
        assert property ($fell(q.sig_en) |-> !q.bias && !q.disp)
        else $error("timing outputs removed while bias on");

    // display comes on last
    a_display_after_bias:
        assert property ($rose(q.disp) |-> q.bias && q.sig_en && q.supply)
        else $error("display on before bias");

    // bias drops only after display is off
    a_bias_after_display:
        assert property ($fell(q.bias) |-> !q.disp && $past(q.state) == FPS_ST_DN_DISP)
        else $error("bias removed while display on");

    // a zero signal up-delay moves to the next step on the first frame pulse
    a_zero_delay_step:
        assert property (q.state == FPS_ST_UP_SIG && $past(q.state) == FPS_ST_OFF && ce_i
                         && signal_delay[`FPS_UP_FIELD] == 4'h0 && frame_sync_pulse_i
                         |=> q.sig_en)
        else $error("zero delay did not end on first pulse");

    // steps end only on a frame pulse
    a_done_on_pulse:
        assert property (q.state != next_q.state && q.state != FPS_ST_OFF
                         && q.state != FPS_ST_ON |-> frame_sync_pulse_i && step_done)
        else $error("step ended without frame pulse");

    // the step counter is never reloaded while idle at either end
    a_no_restart:
        assert property ((q.state == FPS_ST_ON && panel_on_req_i) ||
                         (q.state == FPS_ST_OFF && !panel_on_req_i) |-> !step_load)
        else $error("step started without request change");

    // power comes up first, so every later stage is still off when it rises
    a_supply_first_on:
        assert property ($rose(q.supply) |-> !q.sig_en && !q.bias && !q.disp)
        else $error("logic supply rose after a later stage");

    // display goes off first, while the rest of the panel is still powered
    a_display_first_off:
        assert property ($fell(q.disp) |-> q.bias && q.sig_en && q.supply)
        else $error("display turned off after a later stage");

    // the settled on state keeps every stage up
    a_all_on_held:
        assert property (q.state == FPS_ST_ON |-> q.supply && q.sig_en && q.bias && q.disp)
        else $error("a stage is down while panel on");

    // the settled off state keeps every stage down
    a_all_off_held:
        assert property (q.state == FPS_ST_OFF |-> !q.supply && !q.sig_en && !q.bias && !q.disp)
        else $error("a stage is up while panel off");

    // the group drops while the logic supply still stands
    a_supply_last_off:
        assert property ($fell(q.sig_en) |-> q.supply)
        else $error("timing outputs dropped after logic supply");

    // a power-up in progress never turns back, whatever the request does
    a_up_no_reverse:
        assert property (q.state inside {FPS_ST_UP_SIG, FPS_ST_UP_BIAS, FPS_ST_UP_DISP}
                         |=> !(q.state inside {FPS_ST_OFF, FPS_ST_DN_DISP,
                                               FPS_ST_DN_BIAS, FPS_ST_DN_SIG}))
        else $error("power-up reversed before finishing");

    // with the enable low nothing moves, so a frame pulse in that cycle is not counted
    a_frozen_on_ce:
        assert property (!ce_i |=> q == $past(q))
        else $error("state moved while clock enable low");

    // ****************************************************************
    // cover points
    // ****************************************************************
    // main scenarios: full power-up and power-down, zero field, request bounce, frozen pulse
    c_full_power_up:   cover property ($rose(q.disp));
    c_full_power_down: cover property ($fell(q.supply));
    c_zero_field_step: cover property (step_load && step_val == '0);
    c_req_bounce:      cover property (q.state == FPS_ST_UP_SIG && !panel_on_req_i);
    c_frozen_pulse:    cover property (!ce_i && frame_sync_pulse_i && sequence_busy_o);

endmodule : fps_sequencer

// ===== testbench/fps_panel_model.sv
// panel side model: stamps each power and timing transition with the frame pulse count
`timescale 1ns/1ps
module fps_panel_model (
    input  wire logic             clk_i,   // pixel clock
    input  wire logic             ce_i,    // clock enable seen by the sequencer
    input  wire logic             pulse_i, // frame sync pulse
    input  wire logic [3:0]       lvl_i,   // display, bias, timing group, supply
    output logic      [3:0][15:0] at_o     // pulse count at the last change of each level
);
    logic [15:0] cnt  = 16'h0000; // enabled frame pulses so far
    logic [3:0]  last = 4'h0;     // levels at the previous edge

    // the panel sees only its pins, so a free running count gives the gaps between steps
    always @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (lvl_i[i] !== last[i]) begin
                at_o[i] <= cnt;
            end
        end
        last <= lvl_i;
        if (ce_i && pulse_i) begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule : fps_panel_model

// ===== testbench/tb_top.sv
// self-checking bench of the flat panel power sequencer
`timescale 1ns/1ps
module tb_top;
    logic             clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, req = 1'b0, pulse = 1'b0;
    logic             wr_en = 1'b0, ce_rnd = 1'b0, mark = 1'b1, latch = 1'b1, sh = 1'b1;
    logic [7:0]       idx = 8'h00, wdata = 8'h00, rdata;
    logic [11:0]      dhi = 12'h000, dlo = 12'h000, dhi_o, dlo_o;
    logic             sup, bias, disp, mark_o, latch_o, sh_o, on, busy;
    logic [1:0]       ph = 2'h0;
    logic [3:0][15:0] at;
    logic [7:0]       f [3];
    int               err_total = 0;
    int               cmp_count = 0;

    fps_sequencer DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .panel_on_req_i(req),
        .frame_sync_pulse_i(pulse), .reg_index_i(idx), .reg_write_i(wr_en),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .marker_src_i(mark), .latch_src_i(latch),
        .shclk_src_i(sh), .upper_src_i(dhi), .lower_src_i(dlo), .panel_logic_supply_enable_o(sup),
        .panel_bias_enable_o(bias), .display_on_control_o(disp), .first_line_marker_o(mark_o),
        .line_latch_pulse_o(latch_o), .pixel_shift_clock_out_o(sh_o), .upper_half_data_o(dhi_o),
        .lower_half_data_o(dlo_o), .panel_on_o(on), .sequence_busy_o(busy));

    fps_panel_model PANEL (.clk_i(clk_i), .ce_i(ce_i), .pulse_i(pulse),
        .lvl_i({disp, bias, mark_o & latch_o & sh_o, sup}), .at_o(at));

    // clock
    always #5 clk_i = ~clk_i;

    // frame pulse every fourth cycle; ce is kept high right after a pulse so the
    // timing group's output register never slips past the following pulse
    always @(posedge clk_i) begin
        ph    <= ph + 2'h1;
        pulse <= (ph == 2'h3);
        ce_i  <= !ce_rnd || ph == 2'h0 || ($urandom % 8 != 0);
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] gap(input logic [3:0] n);
        return {28'h0, n} + 32'h1;
    endfunction : gap

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk_i);
        idx   <= i;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_i);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
        @(posedge clk_i);
        idx <= i;
        @(posedge clk_i);
        #1 chk(rdata, e);
    endtask : rdchk

    task automatic wrap_up;
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // bounded wait for a whole sequence; a short request bounce early on must be ignored
    task automatic run_seq(input logic up);
        int n;
        n = 0;
        @(posedge clk_i);
        ce_rnd <= 1'b1;
        req    <= up;
        while ((up ? on !== 1'b1 : (sup !== 1'b0 || busy !== 1'b0)) && n < 3000) begin
            @(posedge clk_i);
            if (n == 2) req <= ~up;
            if (n == 3) req <= up;
            #1 n++;
            if (n == 3) chk(busy, 1'b1);
        end
        if (n >= 3000) begin
            err_total++;
            wrap_up();
        end
        @(posedge clk_i);
        ce_rnd <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : run_seq

    // gated group follows its sources one cycle late when live, else stays low
    task automatic grp_chk(input logic live);
        logic [26:0] v;
        v = 27'($urandom);
        @(posedge clk_i);
        {mark, latch, sh, dhi, dlo} <= v;
        repeat (2) @(posedge clk_i);
        #1 chk({mark_o, latch_o, sh_o, dhi_o, dlo_o}, live ? v : 27'h0);
        @(posedge clk_i);
        {mark, latch, sh} <= 3'h7;
    endtask : grp_chk

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        f = '{8'h31, 8'h23, 8'h12};
        void'($urandom(32'hcccd0bdd));
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdchk(8'h14, 8'h31);
        rdchk(8'h15, 8'h23);
        rdchk(8'h16, 8'h12);
        wr(8'h17, 8'($urandom));
        rdchk(8'h17, 8'h00);
        for (int r = 0; r < 6; r++) begin
            for (int k = 0; k < 3 && r > 0; k++) begin
                f[k] = (r == 1) ? 8'h00 : (r == 2) ? 8'hff : 8'($urandom);
                wr(8'h14 + 8'(k), f[k]);
                rdchk(8'h14 + 8'(k), f[k]);
            end
            grp_chk(1'b0);
            run_seq(1'b1);
            chk({sup, bias, disp, on, busy}, 5'h1e);
            chk(32'(at[1] - at[0]), gap(f[0][7:4]));
            chk(32'(at[2] - at[1]), gap(f[1][7:4]));
            chk(32'(at[3] - at[2]), gap(f[2][7:4]));
            grp_chk(1'b1);
            run_seq(1'b0);
            chk({sup, bias, disp, on, busy}, 5'h00);
            chk(32'(at[2] - at[3]), gap(f[2][3:0]));
            chk(32'(at[1] - at[2]), gap(f[1][3:0]));
            chk(32'(at[0] - at[1]), gap(f[0][3:0]));
        end
        wrap_up();
    end
endmodule : tb_top
